/* File: src/gp8_pin_cell.v */
`timescale 1ns/1ps
// ****************************************************************
// One pin: drive, pull-up and digital input gating
// ****************************************************************
module gp8_pin_cell (
    input  wire pclk,
    input  wire presetn,
    input  wire latch_bit,
    input  wire dir_bit,
    input  wire pull_bit,
    input  wire aidis_bit,
    input  wire analog_pin,
    input  wire periph_oe,
    input  wire periph_out,
    input  wire standby_float,
    input  wire freeze,
    input  wire pin_in,
    output reg  pin_out_q,
    output reg  pin_oe_q,
    output reg  pull_q,
    output reg  din_q
);
    reg  drive_oe;
    reg  drive_val;
    reg  din_ok;

    always @* begin
        drive_oe  = periph_oe | dir_bit;
        drive_val = periph_oe ? periph_out : latch_bit;
        din_ok    = ~analog_pin | aidis_bit;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_q <= 1'b0;
            pin_oe_q  <= 1'b0;
            pull_q    <= 1'b0;
            din_q     <= 1'b0;
        end else if (standby_float) begin
            // Input forced low so an open pin cannot draw leakage current.
            pin_out_q <= 1'b0;
            pin_oe_q  <= 1'b0;
            pull_q    <= 1'b0;
            din_q     <= 1'b0;
        end else if (!freeze) begin
            pin_out_q <= drive_val;
            pin_oe_q  <= drive_oe;
            pull_q    <= pull_bit & ~(drive_oe & ~drive_val);
            din_q     <= din_ok & pin_in;
        end
    end
endmodule // gp8_pin_cell

/* File: src/gp8_port.v */
`timescale 1ns/1ps
`include "gp8_port_regs.vh"
module gp8_port #(
    parameter WIDTH = 8
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [11:0]      paddr,
    input  wire [31:0]      pwdata,
    output reg  [31:0]      prdata,
    output reg              pready,
    output reg              pslverr,
    input  wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] pin_out,
    output wire [WIDTH-1:0] pin_oe,
    output wire [WIDTH-1:0] pull_en,
    output wire [WIDTH-1:0] din,
    input  wire [WIDTH-1:0] periph_oe,
    input  wire [WIDTH-1:0] periph_out,
    input  wire             stop_watch_mode,
    output reg              cmp0_p_en_q,
    output reg              cmp0_n_en_q,
    output reg              cmp1_p_en_q,
    output reg              cmp1_n_en_q
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    reg  [WIDTH-1:0]           port_data_latch_q;
    reg  [WIDTH-1:0]           port_direction_q;
    reg  [WIDTH-1:0]           port_pullup_enable_q;
    reg  [WIDTH-1:0]           analog_input_disable_low_q;
    reg  [`GP8_CTRL_WIDTH-1:0] standby_control_q;
    reg  [WIDTH-1:0]           rd_val;
    reg                        hit;
    wire                       wr_en;
    wire                       access;
    wire                       standby;
    wire                       standby_float;
    wire [WIDTH-1:0]           analog_mask;
    wire [31:0]                rd_word;

    assign access        = psel & penable & ~pready;
    assign wr_en         = access & pwrite;
    assign standby       = stop_watch_mode | standby_control_q[`GP8_CTRL_STBY_BIT];
    assign standby_float = standby & standby_control_q[`GP8_CTRL_PINST_BIT];
    assign analog_mask   = `GP8_ANALOG_MASK;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_data_latch_q          <= `GP8_RST_DATA;
            port_direction_q           <= `GP8_RST_DIR;
            port_pullup_enable_q       <= `GP8_RST_PULLUP;
            analog_input_disable_low_q <= `GP8_RST_AIDIS;
            standby_control_q          <= `GP8_RST_CTRL;
        end else if (wr_en) begin
            case (paddr)
                `GP8_OFF_DATA, `GP8_OFF_DATA_LATCH: begin
                    port_data_latch_q <= pwdata[WIDTH-1:0];
                end
                `GP8_OFF_DIR: begin
                    port_direction_q <= pwdata[WIDTH-1:0];
                end
                `GP8_OFF_PULLUP: begin
                    port_pullup_enable_q <= pwdata[WIDTH-1:0];
                end
                `GP8_OFF_AIDIS: begin
                    analog_input_disable_low_q <= pwdata[WIDTH-1:0];
                end
                `GP8_OFF_CTRL: begin
                    standby_control_q <= pwdata[`GP8_CTRL_WIDTH-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Pins
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
            gp8_pin_cell u_cell (
                .pclk          (pclk),
                .presetn       (presetn),
                .latch_bit     (port_data_latch_q[g]),
                .dir_bit       (port_direction_q[g]),
                .pull_bit      (port_pullup_enable_q[g]),
                .aidis_bit     (analog_input_disable_low_q[g]),
                .analog_pin    (analog_mask[g]),
                .periph_oe     (periph_oe[g]),
                .periph_out    (periph_out[g]),
                .standby_float (standby_float),
                .freeze        (standby),
                .pin_in        (pin_in[g]),
                .pin_out_q     (pin_out[g]),
                .pin_oe_q      (pin_oe[g]),
                .pull_q        (pull_en[g]),
                .din_q         (din[g])
            );
        end
    endgenerate

    // ****************************************************************
    // Comparator input enables
    // ****************************************************************
    // Only the analog-disable, input-off and source-select bits matter here,
    // so the latch and direction never gate the comparator path.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp0_p_en_q <= 1'b0;
            cmp0_n_en_q <= 1'b0;
            cmp1_p_en_q <= 1'b0;
            cmp1_n_en_q <= 1'b0;
        end else begin
            cmp0_p_en_q <= ~analog_input_disable_low_q[`GP8_CMP0_P_PIN]
                           & ~standby_control_q[`GP8_CTRL_INOFF0_BIT];
            cmp1_p_en_q <= ~analog_input_disable_low_q[`GP8_CMP1_P_PIN]
                           & ~standby_control_q[`GP8_CTRL_INOFF1_BIT];
            cmp0_n_en_q <= ~analog_input_disable_low_q[`GP8_CMP0_N_PIN]
                           & ~standby_control_q[`GP8_CTRL_INOFF0_BIT]
                           & ~standby_control_q[`GP8_CTRL_NSRC0_BIT];
            cmp1_n_en_q <= ~analog_input_disable_low_q[`GP8_CMP1_N_PIN]
                           & ~standby_control_q[`GP8_CTRL_INOFF1_BIT]
                           & ~standby_control_q[`GP8_CTRL_NSRC1_BIT];
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    always @* begin
        rd_val = {WIDTH{1'b0}};
        hit    = 1'b1;
        case (paddr)
            `GP8_OFF_DATA: begin
                // Output pins show the latch; other pins show the live level,
                // which includes a peripheral's own drive.
                rd_val = (port_direction_q & ~periph_oe & port_data_latch_q)
                       | (~(port_direction_q & ~periph_oe) & pin_in);
            end
            `GP8_OFF_DATA_LATCH: begin
                rd_val = port_data_latch_q;
            end
            `GP8_OFF_DIR: begin
                rd_val = port_direction_q;
            end
            `GP8_OFF_PULLUP: begin
                rd_val = port_pullup_enable_q;
            end
            `GP8_OFF_AIDIS: begin
                rd_val = analog_input_disable_low_q;
            end
            `GP8_OFF_CTRL: begin
                rd_val = {{(WIDTH-`GP8_CTRL_WIDTH){1'b0}}, standby_control_q};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    assign rd_word = {{(32-WIDTH){1'b0}}, rd_val};

    // One wait state: pready rises in the second access cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (access) begin
            prdata  <= pwrite ? 32'h00000000 : rd_word;
            pready  <= 1'b1;
            pslverr <= ~hit;
        end else begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule // gp8_port

/* File: src/gp8_port_regs.vh */
// Operation
// - Direction one drives pin from latch.
// - Direction zero makes pin an input.
// - Data writes always update the latch.
// - Output pins read back the latch.
// - Input pins read level; modify reads latch.
// - Peripheral output drives pin, readable level.
// - Peripheral input pins read level normally.
// - Disable bit one enables digital input.
// - Reset clears direction and disable bits.
// - Standby select one floats pins, inputs low.
// - Standby select zero holds pin states.
// - Pull-up connects unless pin outputs low.
// - Positive comparator input follows input-off bit.
// - Negative comparator needs both bits zero.
// - Comparator enable ignores latch and direction.
`ifndef GP8_PORT_REGS_VH
`define GP8_PORT_REGS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define GP8_OFF_DATA        12'h000
`define GP8_OFF_DIR         12'h004
`define GP8_OFF_PULLUP      12'h008
`define GP8_OFF_AIDIS       12'h00C
`define GP8_OFF_CTRL        12'h010
`define GP8_OFF_DATA_LATCH  12'h014

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define GP8_CTRL_PINST_BIT  0
`define GP8_CTRL_STBY_BIT   1
`define GP8_CTRL_INOFF0_BIT 2
`define GP8_CTRL_NSRC0_BIT  3
`define GP8_CTRL_INOFF1_BIT 4
`define GP8_CTRL_NSRC1_BIT  5
`define GP8_CTRL_WIDTH      6
`define GP8_RST_DATA        8'h00
`define GP8_RST_DIR         8'h00
`define GP8_RST_PULLUP      8'h00
`define GP8_RST_AIDIS       8'h00
`define GP8_RST_CTRL        6'h00
`define GP8_CMP0_N_PIN      0
`define GP8_CMP0_P_PIN      1
`define GP8_CMP1_N_PIN      3
`define GP8_CMP1_P_PIN      4
`define GP8_ANALOG_MASK     8'hFF

`endif

/* File: verif/gp8_pin_model.sv */
`timescale 1ns/1ps
// ****************
// Pads and board
// ****************
module gp8_pin_model (
    input  logic       pclk,
    input  logic [7:0] pin_out,
    input  logic [7:0] pin_oe,
    input  logic [7:0] pull_en,
    input  logic [7:0] ext_val,
    input  logic [7:0] ext_en,
    output logic [7:0] pin_in
);
    logic [7:0] tog_q = 8'h55;
    // A floating pad toggles, so a stale value can never match by luck.
    always @(posedge pclk) tog_q <= ~tog_q;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                  | (~pin_oe & ~ext_en & (pull_en | tog_q));
endmodule // gp8_pin_model

/* File: verif/gp8_port_assertions.sv */
`timescale 1ns/1ps
module gp8_port_assertions #(
    parameter WIDTH = 8
) (
    input logic             pclk,
    input logic             presetn,
    input logic             psel,
    input logic             penable,
    input logic             pwrite,
    input logic [31:0]      prdata,
    input logic             pready,
    input logic             pslverr,
    input logic [WIDTH-1:0] pin_in,
    input logic [WIDTH-1:0] pin_out,
    input logic [WIDTH-1:0] pin_oe,
    input logic [WIDTH-1:0] pull_en,
    input logic [WIDTH-1:0] din,
    input logic [WIDTH-1:0] periph_oe,
    input logic [WIDTH-1:0] periph_out,
    input logic             stop_watch_mode,
    input logic             cmp0_p_en_q,
    input logic             cmp0_n_en_q,
    input logic             cmp1_p_en_q,
    input logic             cmp1_n_en_q
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence taken_s; psel && penable && !pready; endsequence
    sequence pulse_s; pready ##1 !pready; endsequence
    apb_answer_a: assert property (taken_s |-> ##1 pulse_s) else $error("Late answer");
    err_resp_a: assert property (pslverr |-> pready && prdata == 32'h00000000) else $error("Bad error");
    idle_data_a: assert property (!pready |-> prdata == 32'h00000000) else $error("Stray data");
    rd_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("Upper bits set");
    pull_low_a: assert property ((pull_en & pin_oe & ~pin_out) == 8'h00)
        else $error("Pull-up on low pin");
    periph_drive_a: assert property (!stop_watch_mode && $past(presetn) |=>
        (pin_oe & $past(periph_oe)) == $past(periph_oe) && ((pin_out ^ $past(periph_out)) & $past(periph_oe)) == 8'h00)
        else $error("Peripheral not driving");
    din_gate_a: assert property (!$past(stop_watch_mode) |-> (din & ~$past(pin_in)) == 8'h00)
        else $error("Input not from pin");
    cmp_din_a: assert property (!$past(stop_watch_mode) |->
        !(cmp0_n_en_q && din[0]) && !(cmp0_p_en_q && din[1]) && !(cmp1_n_en_q && din[3]) && !(cmp1_p_en_q && din[4]))
        else $error("Comparator and digital input both on");
    reset_out_a: assert property ($rose(presetn) |-> pin_oe == 8'h00 && din == 8'h00)
        else $error("Outputs after reset");
endmodule // gp8_port_assertions

bind gp8_port gp8_port_assertions #(.WIDTH(WIDTH)) i_gp8_port_assertions (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pull_en(pull_en), .din(din), .periph_oe(periph_oe), .periph_out(periph_out),
    .stop_watch_mode(stop_watch_mode), .cmp0_p_en_q(cmp0_p_en_q), .cmp0_n_en_q(cmp0_n_en_q),
    .cmp1_p_en_q(cmp1_p_en_q), .cmp1_n_en_q(cmp1_n_en_q));

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`include "gp8_port_regs.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stop = 0, err_q;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd_q;
    logic        pready, pslverr, c0p, c0n, c1p, c1n;
    logic [7:0]  pin_in, pin_out, pin_oe, pull_en, din;
    logic [7:0]  periph_oe = 8'h00, periph_out = 8'h00, ext_val = 8'h3C, ext_en = 8'hFF;
    int          fails = 0, cmp_count = 0, cyc = 0;
    always #25 pclk = ~pclk;
    gp8_port #(.WIDTH(8)) i_gp8_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en),
        .din(din), .periph_oe(periph_oe), .periph_out(periph_out), .stop_watch_mode(stop),
        .cmp0_p_en_q(c0p), .cmp0_n_en_q(c0n), .cmp1_p_en_q(c1p), .cmp1_n_en_q(c1n));
    gp8_pin_model i_gp8_pin_model (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_en(pull_en), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Called just after a rising edge; ends one edge after the answer so requests never collide.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_q = prdata; err_q = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d); apb(1, a, {24'h000000, d}); endtask
    task rd(input logic [11:0] a, input logic [7:0] e); apb(0, a, 32'h00000000); `CHK(rd_q, {24'h000000, e}) endtask
    task tick(input int n); repeat (n) @(posedge pclk); endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            tally_and_finish;
        end
    end
    initial begin
        tick(3); presetn <= 1; tick(1);
        for (int i = 1; i < 6; i++) rd(12'(4 * i), 8'h00);
        rd(`GP8_OFF_DATA, 8'h3C);
        apb(0, 12'h018, 32'h00000000); `CHK({err_q, rd_q}, 33'h100000000)
        wr(`GP8_OFF_DATA, 8'hA5); tick(2); `CHK(pin_oe, 8'h00)
        rd(`GP8_OFF_DATA_LATCH, 8'hA5);
        rd(`GP8_OFF_DATA, 8'h3C);
        wr(`GP8_OFF_DIR, 8'h0F); tick(2); `CHK({pin_oe, pin_out[3:0]}, 12'h0F5)
        rd(`GP8_OFF_DATA, 8'h35);
        periph_oe <= 8'h80; periph_out <= 8'h80; tick(2);
        rd(`GP8_OFF_DATA, 8'hB5);
        rd(`GP8_OFF_DATA_LATCH, 8'hA5);
        wr(`GP8_OFF_PULLUP, 8'hFF); tick(2); `CHK(pull_en, 8'hF5)
        periph_oe <= 8'h00; tick(2); `CHK(din, 8'h00)
        wr(`GP8_OFF_AIDIS, 8'hF0); tick(2); `CHK(din, 8'h30)
        wr(`GP8_OFF_AIDIS, 8'hE0);
        wr(`GP8_OFF_PULLUP, 8'hEF); tick(2); `CHK({din, pull_en}, 16'h20E5)
        for (int k = 0; k < 4; k++) begin
            wr(`GP8_OFF_CTRL, {2'b00, k[1], k[0], k[1], k[0], 2'b00}); tick(2);
            `CHK({c0p, c0n, c1p, c1n}, {2{!k[0], !k[0] && !k[1]}})
        end
        wr(`GP8_OFF_CTRL, 8'h00); stop <= 1; tick(2); wr(`GP8_OFF_DATA, 8'h00); tick(2);
        `CHK({pin_oe, pin_out[3:0]}, 12'h0F5)
        stop <= 0; tick(2); `CHK(pin_out[3:0], 4'h0)
        wr(`GP8_OFF_CTRL, 8'h01); stop <= 1; tick(2); `CHK({pin_oe, pull_en, din}, 24'h000000)
        stop <= 0; tick(2);
        tally_and_finish;
    end
endmodule // tb_top
